// ### src/srra_link.sv
// shift logic on the serial clock: captures the frame, shifts out a word
// assumes tx_word and tx_drive are held still while the select is low
`timescale 1ns/1ps
`default_nettype none
module srra_link
  import srra_pkg::*;
(
  // link pins
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // toward the system domain
  input wire logic [31:0] tx_word,
  input wire logic tx_drive,
  output logic [31:0] rx_word,
  output logic [5:0] rx_bits
);

  typedef struct packed {
    logic [31:0] sh;
    logic [5:0] cnt;
    logic [31:0] out;
  } srra_lk_t;

  srra_lk_t q;
  srra_lk_t d;
  logic act_q;
  logic oe_q;

  // ==========================================================
  // frame framing
  // the select cleans up asynchronously because the serial clock
  // may stand still once the frame is over
  always_ff @(posedge sclk or posedge sync_n) begin
    if (sync_n) begin
      act_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      act_q <= 1'b1;
      oe_q <= act_q ? oe_q : tx_drive;
    end
  end

  // ==========================================================
  // shifting
  always_comb begin
    d = q;
    if (!act_q) begin
      d.sh = {31'h0, sdi};
      d.cnt = 6'h01;
      d.out = tx_word;
    end else begin
      d.sh = {q.sh[30:0], sdi};
      d.cnt = (q.cnt == 6'h3f) ? q.cnt : q.cnt + 6'h01;
      d.out = {q.out[30:0], 1'b0};
    end
  end

  // captured bits are left standing after the frame for the system side
  always_ff @(posedge sclk) begin
    q <= d;
  end

  assign sdo = q.out[31];
  assign sdo_oe = oe_q;
  assign rx_word = q.sh;
  assign rx_bits = q.cnt;

endmodule
`default_nettype wire

// ### src/srra_pkg.sv
// constants, types and helpers of the serial register access block
// assumes one 50 MHz system clock on the register side
// Behaviour
// - reset default: 32-bit frames with check byte
// - checking on: only 32-bit frames valid
// - checking off: 24 bits, or 32 ignoring tail
// - act only when address bits match straps
// - bits 20:16 address, 15:0 payload
// - reserved address access sets invalid-access flag
// - four readback modes chosen by mode field
// - select register, next frame shifts it out
// - new select in frame shows next frame
// - readback word starts 0b10, fault, address, data
// - autostatus: status word on every frame
// - status word field order from bit 23
// - shared select: drive only after valid write
// - echo: every second frame echoes last command
// - writing one to bit 13 clears reset flag
// - conversion commands ignored while converter busy
package srra_pkg;

  localparam int FRAME_LONG = 32;
  localparam int FRAME_SHORT = 24;
  localparam int SYS_CLK_MHZ = 50;
  localparam int TRIM_US = 500;
  localparam int TRIM_CYCLES_DEF = TRIM_US * SYS_CLK_MHZ;

  localparam logic [4:0] ADR_KEY = 5'h08;
  localparam logic [4:0] ADR_DIAG_CFG = 5'h10;
  localparam logic [4:0] ADR_ADC_CFG = 5'h11;
  localparam logic [4:0] ADR_RB_SEL = 5'h13;
  localparam logic [4:0] ADR_DIAG_RES = 5'h14;
  localparam logic [4:0] ADR_STATUS = 5'h16;
  localparam logic [15:0] KEY_TRIM = 16'hfcba;

  localparam int CRC_EN_BIT = 0;
  localparam int RB_MODE_LSB = 8;
  localparam int DIAG_TRIM_BIT = 15;
  localparam int DIAG_FRAME_BIT = 14;
  localparam int DIAG_RST_BIT = 13;
  localparam int DIAG_ACCESS_BIT = 12;
  localparam logic [15:0] DIAG_RESET = 16'ha000;
  localparam logic [1:0] RB_HEAD = 2'b10;

  typedef enum logic [1:0] {
    MODE_TWO_STAGE = 2'b00,
    MODE_AUTO = 2'b01,
    MODE_SHARED = 2'b10,
    MODE_ECHO = 2'b11
  } srra_mode_t;

  function automatic logic is_reserved(input logic [4:0] a);
    return (a == 5'h0d) || (a == 5'h0e) || (a >= 5'h19 && a <= 5'h1b) ||
           (a >= 5'h1d);
  endfunction

  function automatic logic is_writable(input logic [4:0] a);
    return (a == 5'h01) || (a >= 5'h03 && a <= 5'h06) ||
           (a >= 5'h09 && a <= 5'h0c) || (a >= 5'h0f && a <= 5'h13);
  endfunction

  function automatic logic [15:0] reg_reset(input logic [4:0] a);
    unique case (a)
      5'h04: return 16'hffff;
      5'h05: return 16'h8000;
      5'h06: return 16'h0c00;
      5'h09: return 16'h0204;
      5'h0a: return 16'h0200;
      5'h0f: return 16'h0009;
      5'h10: return 16'h005d;
      default: return 16'h0000;
    endcase
  endfunction

  // msb-first check code over a 24-bit word
  function automatic logic [7:0] crc8(input logic [23:0] w,
                                      input logic [7:0] poly);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ (((c[7] ^ w[i]) == 1'b1) ? poly : 8'h00);
    end
    return c;
  endfunction

endpackage

// ### src/srra_top.sv
// frame decode, register store and readback word build of the serial block
// assumes the host idles the serial clock between frames and keeps the
// select high for at least 8 system clocks
`timescale 1ns/1ps
`default_nettype none
module srra_top
  import srra_pkg::*;
#(
  parameter logic [7:0] CRC_POLY = 8'h07,
  parameter int unsigned TRIM_CYCLES = TRIM_CYCLES_DEF
) (
  // system
  input wire logic sys_clk,
  input wire logic srst,
  // serial link
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdi,
  output wire logic sdo,
  output wire logic sdo_oe,
  // address straps
  input wire logic dev_addr_hi,
  input wire logic dev_addr_lo,
  // status sources
  input wire logic fault_pin,
  input wire logic ana_diag_flag,
  input wire logic wdt_flag,
  // monitor converter
  input wire logic adc_done,
  input wire logic [11:0] adc_result,
  output logic adc_start,
  output logic [4:0] adc_sel,
  // register write notice
  output logic reg_wr,
  output logic [4:0] reg_wr_addr,
  output logic [15:0] reg_wr_data
);

  typedef struct packed {
    logic sync_s1;
    logic sync_s2;
    logic sync_s3;
    logic [1:0] strap_s1;
    logic [1:0] strap_s2;
    logic [31:0][15:0] regs;
    logic [15:0] diag;
    logic [31:0] tx;
    logic drive;
    logic shared_flag;
    logic echo_ph;
    logic [23:0] last_cmd;
    logic busy;
    logic [4:0] adc_ch;
    logic [11:0] adc_data;
    logic adc_start;
    logic [4:0] adc_sel;
    logic wr;
    logic [4:0] wr_addr;
    logic [15:0] wr_data;
    logic trim_run;
    logic [15:0] trim_cnt;
  } srra_st_t;

  srra_st_t q;
  srra_st_t d;

  logic [31:0] rx_word;
  logic [5:0] rx_bits;
  logic end_ev;
  logic fall_ev;
  logic crc_en;
  logic [23:0] cmd;
  logic len_ok;
  logic crc_ok;
  logic slip_ok;
  logic good;
  logic hit;
  logic [4:0] cmd_addr;
  logic [15:0] cmd_data;

  // ==========================================================
  // link side
  srra_link u_link (
    .sclk(sclk),
    .sync_n(sync_n),
    .sdi(sdi),
    .sdo(sdo),
    .sdo_oe(sdo_oe),
    .tx_word(q.tx),
    .tx_drive(q.drive),
    .rx_word(rx_word),
    .rx_bits(rx_bits)
  );

  // ==========================================================
  // frame decode
  // rx_word and rx_bits are only read right after the select rises,
  // when the serial clock has stopped and they stand still
  assign end_ev = q.sync_s2 & ~q.sync_s3;
  assign fall_ev = ~q.sync_s2 & q.sync_s3;
  assign crc_en = q.regs[ADR_DIAG_CFG][CRC_EN_BIT];
  assign cmd = (!crc_en && rx_bits == 6'(FRAME_SHORT)) ? rx_word[23:0] :
               rx_word[31:8];
  assign len_ok = crc_en ? (rx_bits == 6'(FRAME_LONG)) :
                  (rx_bits == 6'(FRAME_SHORT) ||
                   rx_bits == 6'(FRAME_LONG));
  assign crc_ok = !crc_en || (crc8(rx_word[31:8], CRC_POLY) ==
                              rx_word[7:0]);
  assign slip_ok = cmd[23] ^ cmd[22];
  assign good = len_ok & crc_ok & slip_ok;
  assign hit = good && (cmd[22:21] == q.strap_s2);
  assign cmd_addr = cmd[20:16];
  assign cmd_data = cmd[15:0];

  // ==========================================================
  // state update
  always_comb begin
    logic [15:0] clr;
    logic [15:0] set;
    logic [15:0] rd;
    logic [23:0] w;
    logic [4:0] sel;
    srra_mode_t mode;
    clr = 16'h0000;
    set = 16'h0000;
    rd = 16'h0000;
    w = 24'h000000;
    sel = 5'h00;
    mode = MODE_TWO_STAGE;
    d = q;
    d.sync_s1 = sync_n;
    d.sync_s2 = q.sync_s1;
    d.sync_s3 = q.sync_s2;
    d.strap_s1 = {dev_addr_hi, dev_addr_lo};
    d.strap_s2 = q.strap_s1;
    d.adc_start = 1'b0;
    d.wr = 1'b0;

    if (adc_done) begin
      d.busy = 1'b0;
      d.adc_ch = q.adc_sel;
      d.adc_data = adc_result;
    end

    if (q.trim_run) begin
      d.trim_cnt = q.trim_cnt + 16'h0001;
      if (q.trim_cnt == 16'(TRIM_CYCLES - 1)) begin
        d.trim_run = 1'b0;
        clr[DIAG_TRIM_BIT] = 1'b1;
      end
    end

    if (fall_ev) begin
      d.shared_flag = 1'b0;
    end

    if (end_ev) begin
      if (!good) begin
        set[DIAG_FRAME_BIT] = 1'b1;
      end
      if (hit) begin
        d.last_cmd = cmd;
        if (is_reserved(cmd_addr)) begin
          set[DIAG_ACCESS_BIT] = 1'b1;
        end else begin
          d.shared_flag = 1'b1;
          d.wr = 1'b1;
          d.wr_addr = cmd_addr;
          d.wr_data = cmd_data;
          if (is_writable(cmd_addr)) begin
            d.regs[cmd_addr] = cmd_data;
          end
          if (cmd_addr == ADR_DIAG_RES) begin
            clr = clr | cmd_data;
          end
          if (cmd_addr == ADR_RB_SEL && is_reserved(cmd_data[4:0])) begin
            set[DIAG_ACCESS_BIT] = 1'b1;
          end
          if (cmd_addr == ADR_KEY && cmd_data == KEY_TRIM) begin
            d.trim_run = 1'b1;
            d.trim_cnt = 16'h0000;
          end
          if (cmd_addr == ADR_ADC_CFG && !q.busy) begin
            d.busy = 1'b1;
            d.adc_start = 1'b1;
            d.adc_sel = cmd_data[4:0];
          end
        end
      end
      // hardware sets win over a same-cycle clear
      d.diag = (q.diag & ~clr) | set;

      // readback word for the coming frame
      sel = d.regs[ADR_RB_SEL][4:0];
      mode = srra_mode_t'(d.regs[ADR_RB_SEL][RB_MODE_LSB +: 2]);
      if (sel == ADR_STATUS) begin
        rd = {d.busy, d.adc_ch, d.adc_data[11:2]};
      end else if (sel == ADR_DIAG_RES) begin
        rd = d.diag;
      end else if (is_writable(sel)) begin
        rd = d.regs[sel];
      end
      d.echo_ph = 1'b0;
      d.drive = 1'b1;
      unique case (mode)
        MODE_TWO_STAGE: begin
          w = {RB_HEAD, fault_pin, sel, rd};
        end
        MODE_AUTO: begin
          w = {RB_HEAD, fault_pin, |d.diag, ana_diag_flag, wdt_flag,
               d.busy, d.adc_ch, d.adc_data};
        end
        MODE_SHARED: begin
          w = {RB_HEAD, fault_pin, |d.diag, ana_diag_flag, wdt_flag,
               d.busy, d.adc_ch, d.adc_data};
          d.drive = d.shared_flag;
        end
        MODE_ECHO: begin
          d.echo_ph = ~q.echo_ph;
          w = q.echo_ph ? d.last_cmd :
              {RB_HEAD, fault_pin, |d.diag, ana_diag_flag, wdt_flag,
               d.busy, d.adc_ch, d.adc_data};
        end
      endcase
      // the coming frame runs under the checking setting left by this one
      d.tx = {w, d.regs[ADR_DIAG_CFG][CRC_EN_BIT] ? crc8(w, CRC_POLY) :
              8'h00};
    end else begin
      d.diag = (q.diag & ~clr) | set;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      q <= '0;
      q.sync_s1 <= 1'b1;
      q.sync_s2 <= 1'b1;
      q.sync_s3 <= 1'b1;
      for (int i = 0; i < 32; i++) begin
        q.regs[i] <= reg_reset(5'(i));
      end
      q.diag <= DIAG_RESET;
    end else begin
      q <= d;
    end
  end

  assign adc_start = q.adc_start;
  assign adc_sel = q.adc_sel;
  assign reg_wr = q.wr;
  assign reg_wr_addr = q.wr_addr;
  assign reg_wr_data = q.wr_data;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  bad_frame_quiet_a: assert property (end_ev && !good |=> !reg_wr &&
    q.diag[DIAG_FRAME_BIT]) else $error("bad frame acted on");
  long_only_a: assert property (end_ev && crc_en &&
    rx_bits != 6'(FRAME_LONG) |=> !reg_wr) else
    $error("wrong length accepted");
  short_ok_a: assert property (end_ev && !crc_en && slip_ok && hit &&
    rx_bits == 6'(FRAME_SHORT) && !is_reserved(cmd_addr) |=> reg_wr) else
    $error("short frame refused");
  strap_match_a: assert property (reg_wr |->
    $past(cmd[22:21]) == $past(q.strap_s2)) else
    $error("write to other device");
  write_addr_a: assert property (reg_wr |->
    reg_wr_addr == $past(cmd_addr) && reg_wr_data == $past(cmd_data)) else
    $error("wrong write field");
  reserved_flag_a: assert property (end_ev && hit &&
    is_reserved(cmd_addr) |=> q.diag[DIAG_ACCESS_BIT] && !reg_wr) else
    $error("reserved access missed");
  head_bits_a: assert property ($past(end_ev) && q.tx[31:30] != RB_HEAD
    |-> $past(q.regs[ADR_RB_SEL][RB_MODE_LSB +: 2]) == MODE_ECHO ||
    q.regs[ADR_RB_SEL][RB_MODE_LSB +: 2] == MODE_ECHO) else
    $error("readback head wrong");
  rst_clear_a: assert property (reg_wr && reg_wr_addr == ADR_DIAG_RES &&
    reg_wr_data[DIAG_RST_BIT] |-> !q.diag[DIAG_RST_BIT]) else
    $error("reset flag stuck");
  busy_ignore_a: assert property (adc_start |->
    !$past(q.busy) ##1 q.busy [*2]) else
    $error("start while busy");
  shared_gate_a: assert property (fall_ev |=> !q.shared_flag) else
    $error("shared flag not cleared");
  tx_check_a: assert property ($past(end_ev) && crc_en |->
    q.tx[7:0] == crc8(q.tx[31:8], CRC_POLY)) else
    $error("readback check byte wrong");

  good_write_c: cover property (end_ev && hit);
  echo_frame_c: cover property (end_ev && q.echo_ph);
  conv_start_c: cover property (adc_start);
  bad_frame_c: cover property (end_ev && !good);

endmodule
`default_nettype wire

// ### test/srra_host.sv
// serial host model that frames commands and collects the answer
// assumes the bench calls xfer once at a time and waits for it
`timescale 1ns/1ps
`default_nettype none
module srra_host (
  // link pins
  output logic sclk,
  output logic sync_n,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  // ==========================================================
  // framing
  initial begin
    sclk = 1'b0;
    sync_n = 1'b1;
    sdi = 1'b0;
  end

  // link clock runs only inside a frame, 64 ns period
  task automatic xfer(input int n, input logic [31:0] w,
                      output logic [31:0] r, output logic oe);
    r = 32'h0;
    oe = 1'b0;
    sync_n = 1'b0;
    #13;
    for (int k = n - 1; k >= 0; k--) begin
      sdi = w[k];
      #32 sclk = 1'b1;
      #32 sclk = 1'b0;
      r = {r[30:0], sdo};
      oe = oe | sdo_oe;
    end
    #13 sync_n = 1'b1;
    // no pull on the line, so show the opposite of the last bit
    sdi = ~sdi;
    // gap well above the 8 system clocks the decode needs
    #300;
  endtask
endmodule
`default_nettype wire

// ### test/tb_serial_register_access_readback.sv
// self-checking bench of the serial register access block
// assumes the host model drives the link and the bench the rest
`timescale 1ns/1ps
`default_nettype none
module tb_serial_register_access_readback;
  import srra_pkg::*;
  localparam logic [7:0] POLY = 8'h07;
  logic sys_clk, srst, sclk, sync_n, sdi, sdo, sdo_oe, oe;
  logic hi, lo, fault, ana, wdt, adc_done, adc_start, reg_wr;
  logic [11:0] adc_result;
  logic [4:0] adc_sel, reg_wr_addr;
  logic [15:0] reg_wr_data;
  logic [31:0] rd, r2, rnd;
  logic [23:0] st;
  int errors = 0, total_checks = 0, wr_cnt = 0, st_cnt = 0, seed, n;

  srra_top #(.CRC_POLY(POLY), .TRIM_CYCLES(20)) srra_top_inst (
    .sys_clk(sys_clk), .srst(srst), .sclk(sclk), .sync_n(sync_n),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .dev_addr_hi(hi),
    .dev_addr_lo(lo), .fault_pin(fault), .ana_diag_flag(ana),
    .wdt_flag(wdt), .adc_done(adc_done), .adc_result(adc_result),
    .adc_start(adc_start), .adc_sel(adc_sel), .reg_wr(reg_wr),
    .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data));
  srra_host srra_host_inst (.sclk(sclk), .sync_n(sync_n), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe));

  // ==========================================================
  // reference model
  function automatic logic [7:0] seal8(input logic [23:0] w);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? POLY : 8'h00);
    end
    return c;
  endfunction
  function automatic logic [23:0] cmd(input logic [4:0] a,
                                      input logic [15:0] d);
    return {~hi, hi, lo, a, d};
  endfunction
  function automatic logic [31:0] fr(input logic [23:0] c);
    return {c, seal8(c)};
  endfunction
  function automatic logic [31:0] rbw(input logic [4:0] a,
                                      input logic [15:0] d);
    return fr({2'b10, fault, a, d});
  endfunction

  // ==========================================================
  // checking and closing
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    if (errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic send(input logic [4:0] a, input logic [15:0] d);
    srra_host_inst.xfer(32, fr(cmd(a, d)), rd, oe);
  endtask

  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (reg_wr === 1'b1) wr_cnt++;
    if (adc_start === 1'b1) st_cnt++;
  end
  initial begin
    #1000000;
    errors++;
    conclude();
  end

  // ==========================================================
  // scenarios
  initial begin
    seed = 32'hd077bac8;
    rnd = $random(seed);
    {hi, lo, fault, ana, wdt} = rnd[4:0];
    sys_clk = 1'b0;
    srst = 1'b1;
    adc_done = 1'b0;
    adc_result = 12'h000;
    repeat (3) @(negedge sys_clk);
    srst = 1'b0;
    repeat (2) @(negedge sys_clk);
    send(ADR_RB_SEL, 16'h0014);
    chk("first drive", 32'h0, {31'h0, oe});
    chk("write", {11'h0, ADR_RB_SEL, 16'h0014},
        {11'h0, reg_wr_addr, reg_wr_data});
    send(ADR_RB_SEL, 16'h0010);
    chk("select read", rbw(ADR_DIAG_RES, DIAG_RESET), rd);
    send(5'h00, 16'h0000);
    chk("piped read", rbw(ADR_DIAG_CFG, 16'h005d), rd);
    send(ADR_RB_SEL, 16'h0014);
    n = wr_cnt;
    srra_host_inst.xfer(32, fr(cmd(5'h04, rnd[31:16])) ^ 32'h1, rd,
                        oe);
    srra_host_inst.xfer(31, fr(cmd(5'h04, rnd[31:16])) >> 1, rd,
                        oe);
    srra_host_inst.xfer(32, fr({hi, ~hi, ~lo, 5'h04, rnd[31:16]}), rd,
                        oe);
    send(5'h0d, 16'h0000);
    chk("refused writes", n, wr_cnt);
    send(5'h00, 16'h0000);
    chk("error flags", rbw(ADR_DIAG_RES, 16'hf000), rd);
    send(ADR_DIAG_RES, 16'h2000);
    send(5'h00, 16'h0000);
    chk("flag cleared", rbw(ADR_DIAG_RES, 16'hd000), rd);
    n = st_cnt;
    send(ADR_ADC_CFG, 16'h0405);
    chk("conversions", n + 1, st_cnt);
    send(ADR_ADC_CFG, 16'h0407);
    chk("busy refusal", n + 1, st_cnt);
    chk("channel", 32'h5, {27'h0, adc_sel});
    rnd = $random(seed);
    @(negedge sys_clk);
    adc_done = 1'b1;
    adc_result = rnd[11:0];
    @(negedge sys_clk);
    adc_done = 1'b0;
    send(ADR_RB_SEL, 16'h0100);
    st = {2'b10, fault, 1'b1, ana, wdt, 1'b0, 5'h05, rnd[11:0]};
    send(5'h03, rnd[31:16]);
    chk("status", fr(st), rd);
    send(5'h00, 16'h0000);
    chk("status again", fr(st), rd);
    send(ADR_RB_SEL, 16'h0300);
    send(5'h03, 16'h1111);
    r2 = rd;
    send(5'h03, 16'h2222);
    chk("echo", 32'h1, {31'h0, (r2 === fr(st) &&
        rd === fr(cmd(5'h03, 16'h1111))) || (rd === fr(st) &&
        r2 === fr(cmd(ADR_RB_SEL, 16'h0300)))});
    send(ADR_RB_SEL, 16'h0200);
    srra_host_inst.xfer(32, fr({hi, ~hi, ~lo, 5'h00, 16'h0}), rd, oe);
    chk("shared drive", 32'h1, {31'h0, oe});
    chk("shared status", fr(st), rd);
    send(5'h00, 16'h0000);
    chk("shared quiet", 32'h0, {31'h0, oe});
    send(ADR_DIAG_CFG, 16'h005c);
    n = wr_cnt;
    srra_host_inst.xfer(24, {8'h0, cmd(5'h03, 16'h3c3c)}, rd, oe);
    srra_host_inst.xfer(32, {cmd(5'h03, 16'h5a5a), rnd[7:0]}, rd,
                        oe);
    chk("unchecked writes", n + 2, wr_cnt);
    chk("last data", 32'h5a5a, {16'h0, reg_wr_data});
    n = wr_cnt;
    send(5'h0c, 16'h0000);
    send(5'h0b, 16'h0000);
    send(5'h06, 16'h0100);
    send(5'h01, 16'h0000);
    send(5'h06, 16'h0140);
    chk("sequence writes", n + 5, wr_cnt);
    chk("sequence data", 32'h0140, {16'h0, reg_wr_data});
    send(ADR_KEY, KEY_TRIM);
    send(ADR_RB_SEL, 16'h0014);
    send(5'h00, 16'h0000);
    chk("trim done", {2'b10, fault, ADR_DIAG_RES, 16'h5000, 8'h00},
        rd);
    conclude();
  end
endmodule
`default_nettype wire
